/* File: verilog/tmcs_pkg.sv */
// Package for the test-mode clock control and sync pulse generator
`default_nettype none
package tmcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and fixed values
    localparam int unsigned DIV_W     = 4;
    localparam int unsigned MULT_W    = 3;
    localparam int unsigned MULT_MAX  = 8;
    localparam logic [3:0]  GEAR_LO   = 4'h8;   // 1:8 gear
    localparam logic [3:0]  GEAR_MID  = 4'hB;   // 1:11 gear
    localparam logic [3:0]  GEAR_HI   = 4'hF;   // 1:15 gear
    localparam logic [3:0]  CNT_ZERO  = 4'h0;
    localparam logic [3:0]  CNT_ONE   = 4'h1;
    localparam logic [3:0]  PRE_OFS   = 4'h2;   // Decode lead for two flops
    localparam logic [2:0]  MULT_ONE  = 3'h1;   // Slow multiplier in test
    localparam logic [2:0]  MULT_ZERO = 3'h0;

    // Reset values of the active divider settings
    localparam logic [3:0]  RST_CORE_DIV   = 4'h8;
    localparam logic [2:0]  RST_MEM_MULT   = 3'h3;
    localparam logic [3:0]  RST_PERIPH_DIV = 4'h4;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        TMCS_MISSION,
        TMCS_CHANGE,
        TMCS_IN_RST,
        TMCS_TEST
    } tmcs_mode_t;

    typedef struct packed {
        logic              test_mode_variant_one;
        logic              test_mode_variant_two;
        logic              freq_change;
        logic [DIV_W-1:0]  core_divider_setting;
        logic [MULT_W-1:0] mem_mult;
        logic [DIV_W-1:0]  periph_div;
    } tmcs_cfg_t;

    typedef struct packed {
        logic core_to_mem;
        logic mem_to_core;
        logic core_to_periph;
        logic periph_to_core;
        logic core_to_dbl;
        logic dbl_to_core;
        logic core_to_sys;
        logic sys_to_core;
    } tmcs_sync_t;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic tmcs_gear_ok(input logic [3:0] n);
        return (n == GEAR_LO) || (n == GEAR_MID) || (n == GEAR_HI);
    endfunction : tmcs_gear_ok

    function automatic logic [3:0] tmcs_wrap_add(input logic [3:0] c,
                                                 input logic [3:0] off,
                                                 input logic [3:0] n);
        logic [4:0] s;
        s = {1'b0, c} + {1'b0, off};
        if (s >= {1'b0, n}) s = s - {1'b0, n};
        if (s >= {1'b0, n}) s = s - {1'b0, n};
        return s[3:0];
    endfunction : tmcs_wrap_add

    function automatic logic [3:0] tmcs_half(input logic [3:0] n);
        logic [4:0] s;
        s = ({1'b0, n} + 5'h0_1) >> 1;
        return s[3:0];
    endfunction : tmcs_half

    // Fast-to-slow enable at floor(k*N/M)
    function automatic logic tmcs_f2s_hit(input logic [3:0] c,
                                          input logic [3:0] n,
                                          input logic [2:0] m);
        logic hit;
        int   mm;
        hit = 1'b0;
        mm  = (m == MULT_ZERO) ? 1 : int'(m);
        for (int k = 0; k < MULT_MAX; k++) begin
            if (k < mm && (k * int'(n)) / mm == int'(c)) hit = 1'b1;
        end
        return hit;
    endfunction : tmcs_f2s_hit

    // Slow-to-fast enable at floor((k+1)*N/M - 1)
    function automatic logic tmcs_s2f_hit(input logic [3:0] c,
                                          input logic [3:0] n,
                                          input logic [2:0] m);
        logic hit;
        int   mm;
        hit = 1'b0;
        mm  = (m == MULT_ZERO) ? 1 : int'(m);
        for (int k = 0; k < MULT_MAX; k++) begin
            if (k < mm && ((k + 1) * int'(n)) / mm - 1 == int'(c))
                hit = 1'b1;
        end
        return hit;
    endfunction : tmcs_s2f_hit

endpackage : tmcs_pkg
`default_nettype wire

/* File: verilog/tmcs_clk_ctl.sv */
// Test-mode clock control with fractional-ratio sync pulse generation
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RQ1 - Test mode clocks peripheral lanes at memory rate
// RQ2 - Peripheral pulses copy memory pulses in test
// RQ3 - Only 1:8, 1:11, 1:15 ratios allowed
// RQ4 - Gear chosen by core divider alone
// RQ5 - Core mux functional, memory mux bypassed
// RQ6 - Clusters get virtual clock divided from core
// RQ7 - Virtual clock duty 50/50, 55/45, 53/47
// RQ8 - Serial lane clock inverted against peripheral
// RQ9 - System pair fixed, others follow divider
// RQ10 - Software sets mode, divider, change field
// RQ11 - Both variants set means variant one
// RQ12 - Reset unit warm-resets on change request
// RQ13 - Dividers taken at reset release
// RQ14 - Serial flag change in reset disables select
// RQ15 - Fast-to-slow enable one cycle before launch
// RQ16 - Slow-to-fast enable one cycle before capture
// RQ17 - Pattern repeats every N fast cycles
// RQ18 - Fast-to-slow pulse at floor(kN/M)
// RQ19 - Slow-to-fast pulse at floor((k+1)N/M-1)
// RQ20 - Slow index counts from zero at alignment
// RQ21 - Positions hold after one cluster flop
// RQ22 - Wrapping core counter cleared at alignment
module tmcs_clk_ctl
    import tmcs_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Programmed PLL control fields
    input  wire tmcs_cfg_t  cfg_i,
    // Reset unit
    input  wire logic       rst_active_i,
    output logic            freq_change_rst_req_o,
    // PLL divider and mux controls
    output logic [3:0]      pll_core_div_o,
    output logic [2:0]      pll_mem_mult_o,
    output logic            core_mux_bypass_o,
    output logic            mem_mux_bypass_o,
    // Cluster header controls
    output logic            test_active_o,
    output logic            variant_one_active_o,
    output logic            serdes_test_flag_o,
    output logic            serial_sel_disable_o,
    output logic            cluster_virt_sel_o,
    output logic            ratio_err_o,
    // Cluster clocks
    output logic            virt_mem_clk_o,
    output logic            serial_lane_clk_o,
    // Sync pulses
    output var tmcs_sync_t  sync_o
);

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencing state
    tmcs_mode_t state_q, state_d;
    tmcs_cfg_t  pend_q, pend_d;
    logic [3:0] core_div_q, core_div_d;
    logic [2:0] mem_mult_q, mem_mult_d;
    logic [3:0] periph_div_q, periph_div_d;
    logic       var_one_q, var_one_d;
    logic       serdes_q, serdes_d;
    logic       err_q, err_d;
    logic       req_test;
    logic       req_ok;

    // Request decode
    always_comb begin
        req_test = cfg_i.test_mode_variant_one | cfg_i.test_mode_variant_two;
        req_ok   = req_test ? tmcs_gear_ok(cfg_i.core_divider_setting) // see RQ3
                 : (cfg_i.core_divider_setting != CNT_ZERO)
                   && (cfg_i.mem_mult != MULT_ZERO)
                   && (cfg_i.periph_div != CNT_ZERO);
    end

    // Next mode, pending and active settings
    always_comb begin
        state_d      = state_q;
        pend_d       = pend_q;
        core_div_d   = core_div_q;
        mem_mult_d   = mem_mult_q;
        periph_div_d = periph_div_q;
        var_one_d    = var_one_q;
        serdes_d     = serdes_q;
        err_d        = err_q;
        unique case (state_q)
            TMCS_MISSION, TMCS_TEST: begin
                if (cfg_i.freq_change) begin
                    err_d = !req_ok;                     // see RQ3
                    if (req_ok) begin
                        pend_d  = cfg_i;
                        state_d = TMCS_CHANGE;
                    end
                end
            end
            TMCS_CHANGE: begin
                if (rst_active_i) state_d = TMCS_IN_RST;
            end
            TMCS_IN_RST: begin
                // Flag follows the request while reset is held
                serdes_d = pend_q.test_mode_variant_one
                         | pend_q.test_mode_variant_two;   // see RQ14
                if (!rst_active_i) begin
                    // Dividers land only at the release edge
                    core_div_d = pend_q.core_divider_setting; // see RQ13
                    if (!serdes_d) begin
                        mem_mult_d   = pend_q.mem_mult;    // see RQ4
                        periph_div_d = pend_q.periph_div;
                    end
                    var_one_d = pend_q.test_mode_variant_one; // see RQ11
                    state_d   = serdes_d ? TMCS_TEST : TMCS_MISSION;
                end
            end
        endcase
    end

    // Mode registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q      <= TMCS_MISSION;
            pend_q       <= '0;
            core_div_q   <= RST_CORE_DIV;
            mem_mult_q   <= RST_MEM_MULT;
            periph_div_q <= RST_PERIPH_DIV;
            var_one_q    <= 1'b0;
            serdes_q     <= 1'b0;
            err_q        <= 1'b0;
        end else begin
            state_q      <= state_d;
            pend_q       <= pend_d;
            core_div_q   <= core_div_d;
            mem_mult_q   <= mem_mult_d;
            periph_div_q <= periph_div_d;
            var_one_q    <= var_one_d;
            serdes_q     <= serdes_d;
            err_q        <= err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core-clock counters, virtual clock and sync pulses
    logic       test_on;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] pcnt_q, pcnt_d;
    logic       vclk_q, vclk_d;
    logic       lane_q, lane_d;
    tmcs_sync_t sync_q, sync_d;
    logic [2:0] mem_m;
    logic [3:0] pre;
    logic [3:0] ppre;

    // Core counter wraps every N core cycles, system-pair counter every periph_div; both clear at the aligned edge
    always_comb begin
        test_on = (state_q == TMCS_TEST);
        if (state_q == TMCS_IN_RST)
            cnt_d = CNT_ZERO;                            // see RQ20
        else if (cnt_q >= core_div_q - CNT_ONE)
            cnt_d = CNT_ZERO;                            // see RQ17
        else
            cnt_d = cnt_q + CNT_ONE;                     // see RQ22
        if (state_q == TMCS_IN_RST || pcnt_q >= periph_div_q - CNT_ONE)
            pcnt_d = CNT_ZERO;
        else
            pcnt_d = pcnt_q + CNT_ONE;
    end

    // Virtual clock high for ceil(N/2) core cycles, lane clock inverted
    always_comb begin
        vclk_d = (state_d == TMCS_TEST)
               && (cnt_d < tmcs_half(core_div_d));       // see RQ6, RQ7
        lane_d = (state_d == TMCS_TEST) && !vclk_d;      // see RQ8
    end

    // Pulses decoded two cycles ahead so the cluster flop lands on index
    always_comb begin
        mem_m  = test_on ? MULT_ONE : mem_mult_q;         // see RQ4
        pre    = tmcs_wrap_add(cnt_q, PRE_OFS, core_div_q); // see RQ21
        ppre   = tmcs_wrap_add(pcnt_q, PRE_OFS, periph_div_q);
        sync_d = '0;
        if (test_on || state_q == TMCS_MISSION) begin
            sync_d.core_to_mem = tmcs_f2s_hit(pre, core_div_q, mem_m); // see RQ15, RQ18
            sync_d.mem_to_core = tmcs_s2f_hit(pre, core_div_q, mem_m); // see RQ16, RQ19
            // System pair never moves with the gear
            sync_d.core_to_sys = tmcs_f2s_hit(ppre, periph_div_q, MULT_ONE); // see RQ9
            sync_d.sys_to_core = tmcs_s2f_hit(ppre, periph_div_q, MULT_ONE);
            if (test_on) begin
                sync_d.core_to_periph = sync_d.core_to_mem;  // see RQ2
                sync_d.periph_to_core = sync_d.mem_to_core;
                sync_d.core_to_dbl    = sync_d.core_to_mem;  // see RQ9
                sync_d.dbl_to_core    = sync_d.mem_to_core;
            end else begin
                sync_d.core_to_periph = sync_d.core_to_sys;
                sync_d.periph_to_core = sync_d.sys_to_core;
                sync_d.core_to_dbl    = sync_d.core_to_sys;
                sync_d.dbl_to_core    = sync_d.sys_to_core;
            end
        end
    end

    // Clock generation registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q  <= CNT_ZERO;
            pcnt_q <= CNT_ZERO;
            vclk_q <= 1'b0;
            lane_q <= 1'b0;
            sync_q <= '0;
        end else begin
            cnt_q  <= cnt_d;
            pcnt_q <= pcnt_d;
            vclk_q <= vclk_d;
            lane_q <= lane_d;
            sync_q <= sync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign freq_change_rst_req_o = (state_q == TMCS_CHANGE);  // see RQ12
    assign pll_core_div_o        = core_div_q;
    assign pll_mem_mult_o        = mem_mult_q;
    assign core_mux_bypass_o     = 1'b0;                     // see RQ5
    assign mem_mux_bypass_o      = test_on;                  // see RQ5
    assign test_active_o         = test_on;
    assign variant_one_active_o  = var_one_q;
    assign serdes_test_flag_o    = serdes_q;
    assign serial_sel_disable_o  = serdes_q;                 // see RQ14
    assign cluster_virt_sel_o    = test_on;                  // see RQ1
    assign ratio_err_o           = err_q;
    assign virt_mem_clk_o        = vclk_q;
    assign serial_lane_clk_o     = lane_q;
    assign sync_o                = sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    logic [3:0] hi_len_q;

    // High-phase length of the virtual clock
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) hi_len_q <= CNT_ZERO;
        else         hi_len_q <= vclk_q ? hi_len_q + CNT_ONE : CNT_ZERO;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_gear_legal: assert property (test_on |-> tmcs_gear_ok(core_div_q)) // see RQ3
        else $error("Test mode running with illegal gear");
    a_mux_modes: assert property (test_on |-> mem_mux_bypass_o
                                  && !core_mux_bypass_o) // see RQ5
        else $error("Clock mux modes wrong in test mode");
    a_lane_inverted: assert property (test_on && $past(test_on)
                                      |-> serial_lane_clk_o != virt_mem_clk_o) // see RQ8
        else $error("Lane clock not inverted");
    a_periph_follow: assert property (test_on |-> sync_o.core_to_periph
                     == sync_o.core_to_mem && sync_o.periph_to_core
                     == sync_o.mem_to_core) // see RQ2
        else $error("Peripheral pulses differ from memory pulses");
    a_duty_high: assert property (test_on && $fell(virt_mem_clk_o)
                                  |-> hi_len_q == tmcs_half(core_div_q)) // see RQ7
        else $error("Virtual clock high phase wrong");
    a_cnt_wrap: assert property (cnt_q == core_div_q - CNT_ONE
                                 && state_q != TMCS_IN_RST
                                 |=> cnt_q == CNT_ZERO) // see RQ22
        else $error("Counter did not wrap at N");
    a_f2s_place: assert property (test_on && sync_o.core_to_mem
                                  |-> cnt_q == core_div_q - CNT_ONE) // see RQ18
        else $error("Fast-to-slow pulse misplaced");
    a_s2f_place: assert property (test_on && sync_o.mem_to_core
                                  |-> cnt_q == core_div_q - PRE_OFS) // see RQ19
        else $error("Slow-to-fast pulse misplaced");
    a_div_release: assert property (state_q == TMCS_IN_RST && !rst_active_i
                    |=> core_div_q == $past(pend_q.core_divider_setting)
                    && cnt_q == CNT_ZERO) // see RQ13
        else $error("Divider not taken at reset release");
    a_variant_prio: assert property (state_q == TMCS_IN_RST && !rst_active_i
                    && pend_q.test_mode_variant_one
                    |=> variant_one_active_o) // see RQ11
        else $error("Variant one not active");
    a_flag_in_rst: assert property (state_q == TMCS_IN_RST
                    |=> serdes_test_flag_o == $past(pend_q.test_mode_variant_one
                    | pend_q.test_mode_variant_two)) // see RQ14
        else $error("Serial test flag not updated in reset");

    c_gear_lo:  cover property (test_on && core_div_q == GEAR_LO);
    c_gear_mid: cover property (test_on && core_div_q == GEAR_MID);
    c_gear_hi:  cover property (test_on && core_div_q == GEAR_HI);
    c_back_out: cover property (state_q == TMCS_TEST ##[1:1000]
                                state_q == TMCS_MISSION);

endmodule : tmcs_clk_ctl
`default_nettype wire

/* File: sim/tmcs_rst_model.sv */
// Behavioural reset unit that answers frequency-change requests
`timescale 1ns/100ps
`default_nettype none
module tmcs_rst_model (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Request and pacing
    input  wire logic       req_i,
    input  wire logic [3:0] delay_i,
    input  wire logic [3:0] hold_i,
    // Warm reset
    output var  logic       rst_active_o
);
    ////////////////////////////////////////////////////////////////////
    // Warm reset after a set delay, held for a set span
    initial rst_active_o = 1'b0;
    always begin
        @(posedge sys_clk_i);
        if (nrst_i && req_i) begin
            repeat (delay_i) @(posedge sys_clk_i);
            rst_active_o <= 1'b1;
            repeat (hold_i) @(posedge sys_clk_i);
            rst_active_o <= 1'b0;
        end
    end
endmodule : tmcs_rst_model
`default_nettype wire

/* File: sim/test_test_mode_clock_sync_pulse_gen.sv */
// Self-checking bench for the test-mode clock control block
`timescale 1ns/100ps
`default_nettype none
module test_test_mode_clock_sync_pulse_gen
    import tmcs_pkg::*;
;
    logic       clk  = 1'b0;
    logic       nrst = 1'b0;
    tmcs_cfg_t  cfg  = '0;
    logic       rst_act, req_o, mux_c, mux_m, test_o, v1_o, flag_o;
    logic       dis_o, vsel, err_o, vclk, lclk;
    logic [3:0] div_o;
    logic [3:0] dly = 4'h0;
    logic [3:0] hld = 4'h3;
    logic [2:0] mult_o;
    tmcs_sync_t sync;
    logic [3:0] bad [3] = '{4'h9, 4'hC, 4'h0};
    logic [3:0] gears [3] = '{GEAR_LO, GEAR_MID, GEAR_HI};
    logic [3:0] n;
    logic [2:0] m;
    logic [3:0] pdv = RST_PERIPH_DIV; // Active system-pair divider
    int         error_cnt   = 0;
    int         check_count = 0;

    // Core clock, 10 ns period
    always #5 clk = ~clk;

    tmcs_clk_ctl dut (
        .sys_clk_i(clk), .nrst_i(nrst), .cfg_i(cfg),
        .rst_active_i(rst_act), .freq_change_rst_req_o(req_o),
        .pll_core_div_o(div_o), .pll_mem_mult_o(mult_o),
        .core_mux_bypass_o(mux_c), .mem_mux_bypass_o(mux_m),
        .test_active_o(test_o), .variant_one_active_o(v1_o),
        .serdes_test_flag_o(flag_o), .serial_sel_disable_o(dis_o),
        .cluster_virt_sel_o(vsel), .ratio_err_o(err_o),
        .virt_mem_clk_o(vclk), .serial_lane_clk_o(lclk), .sync_o(sync)
    );

    tmcs_rst_model partner (
        .sys_clk_i(clk), .nrst_i(nrst), .req_i(req_o),
        .delay_i(dly), .hold_i(hld), .rst_active_o(rst_act)
    );

    ////////////////////////////////////////////////////////////////////
    // Comparison, waiting and stimulus helpers
    task automatic chkv(input string nm, input logic [3:0] e,
                        input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chkv

    task automatic chk1(input string nm, input logic e, input logic g);
        chkv(nm, 4'(e), 4'(g));
    endtask : chk1

    task automatic wait_lvl(ref logic s, input logic v);
        int w;
        w = 0;
        while (s !== v && w < 60) begin
            @(negedge clk);
            w++;
        end
        chk1("handshake", v, s);
    endtask : wait_lvl

    // One-cycle change request with random reset-unit pacing
    task automatic request(input logic a, input logic b,
                           input logic [3:0] nd, input logic [2:0] md,
                           input logic [3:0] pd);
        @(negedge clk);
        cfg = '{a, b, 1'b1, nd, md, pd};
        dly = 4'($urandom_range(3));
        hld = 4'($urandom_range(10, 3));
        @(negedge clk);
        cfg.freq_change = 1'b0;
    endtask : request

    // Pulses in a window of nd cycles, expected md per direction
    task automatic count_pulses(input int nd, input int md);
        int a;
        int b;
        a = 0;
        b = 0;
        repeat (nd) begin
            @(negedge clk);
            a += int'(sync.core_to_mem);
            b += int'(sync.mem_to_core);
        end
        chkv("f2s_count", 4'(md), 4'(a));
        chkv("s2f_count", 4'(md), 4'(b));
    endtask : count_pulses

    // Enter one gear and follow the clocks and pulses over three periods
    task automatic gear(input logic a, input logic b, input logic [3:0] nd);
        int k;
        int nn;
        int pp;
        logic [2:0] old;
        nn  = int'(nd);
        pp  = int'(pdv);
        old = mult_o;
        request(a, b, nd, MULT_ONE, 4'h4);
        wait_lvl(req_o, 1'b1);
        wait_lvl(rst_act, 1'b1);
        wait_lvl(test_o, 1'b1);
        chk1("ratio_err", 1'b0, err_o);
        chkv("core_div", nd, div_o);
        chkv("mem_mult", 4'(old), 4'(mult_o));
        chk1("var_one", a, v1_o);
        chk1("mem_bypass", 1'b1, mux_m);
        chk1("core_bypass", 1'b0, mux_c);
        chk1("virt_sel", 1'b1, vsel);
        chk1("sel_off", 1'b1, dis_o);
        chk1("flag", 1'b1, flag_o);
        for (k = 0; k < 3 * nn; k++) begin
            chk1("virt_clk", (k % nn) < (nn + 1) / 2, vclk);
            chk1("lane_clk", (k % nn) >= (nn + 1) / 2, lclk);
            chk1("f2s", (k % nn) == nn - 1, sync.core_to_mem);
            chk1("s2f", (k % nn) == nn - 2, sync.mem_to_core);
            chk1("periph_f2s", sync.core_to_mem, sync.core_to_periph);
            chk1("periph_s2f", sync.mem_to_core, sync.periph_to_core);
            chk1("dbl_f2s", sync.core_to_mem, sync.core_to_dbl);
            chk1("dbl_s2f", sync.mem_to_core, sync.dbl_to_core);
            chk1("sys_f2s", (k % pp) == pp - 1, sync.core_to_sys);
            chk1("sys_s2f", (k % pp) == (2 * pp - 2) % pp,
                 sync.sys_to_core);
            @(negedge clk);
        end
    endtask : gear

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(27104));
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        chkv("core_div", RST_CORE_DIV, div_o);
        chk1("test", 1'b0, test_o);
        count_pulses(8, 3);
        for (int i = 0; i < 3; i++) begin
            request(i != 2, 1'($urandom), bad[i], MULT_ONE, 4'h4);
            repeat (3) @(negedge clk);
            chk1("ratio_err", 1'b1, err_o);
            chk1("no_req", 1'b0, req_o);
            chk1("test", 1'b0, test_o);
        end
        gear(1'b1, 1'b0, GEAR_LO);
        gear(1'b1, 1'b1, GEAR_MID);
        gear(1'b0, 1'b1, GEAR_HI);
        repeat (4) gear(1'($urandom), 1'b1, gears[$urandom_range(2)]);
        // Back to mission with random dividers
        n = 4'($urandom_range(15, 8));
        m = 3'($urandom_range(7, 1));
        pdv = 4'($urandom_range(15, 1));
        request(1'b0, 1'b0, n, m, pdv);
        wait_lvl(rst_act, 1'b1);
        wait_lvl(rst_act, 1'b0);
        repeat (3) @(negedge clk);
        chkv("core_div", n, div_o);
        chkv("mem_mult", 4'(m), 4'(mult_o));
        chk1("test", 1'b0, test_o);
        chk1("flag", 1'b0, flag_o);
        chk1("virt_clk", 1'b0, vclk);
        count_pulses(int'(n), int'(m));
        // Reset in the middle of test mode
        gear(1'b1, 1'b0, GEAR_MID);
        nrst = 1'b0;
        @(negedge clk);
        chk1("test", 1'b0, test_o);
        chkv("core_div", RST_CORE_DIV, div_o);
        chk1("virt_clk", 1'b0, vclk);
        nrst = 1'b1;
        count_pulses(8, 3);
        report_and_stop();
    end

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule : test_test_mode_clock_sync_pulse_gen
`default_nettype wire
